// [src/stm_core.sv]
// standard timer core: 10-bit up counter, period and compare A comparators,
// waveform output and capture, reached over a plain strobe register port
// assumes one clock, synchronous active-high reset, async pins synchronised here
//
// What this block does
// - ten-bit up counter on selected clock
// - period value compared to counter bits 9..7
// - compare A checks all ten counter bits
// - software clears count only via enable rise
// - overflow or selected match clears, raises interrupt
// - pause bit holds count, resume from held
// - clock select picks one of eight sources
// - enable low stops counter, keeps value
// - enable rising edge zeroes the counter
// - enable rise restores initial output level
// - period n gives n*128 clocks, zero 1024
// - period match clears when clear source zero
// - mode field selects compare, capture, PWM, timer
// - timer mode output level is undefined
// - compare A match: none, low, high, toggle
// - PWM mode: inactive, active, PWM, single pulse
// - capture on rise, fall, both, or off
// - requested level equal initial gives no change
// - clear source: period/overflow or compare A
// - output control sets compare mode initial level
// - polarity inverts output except timer mode
// - low bytes go through shared 8-bit buffer
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module stm_core #(
  parameter int CNT_W = stm_pkg::CNT_W // counter width
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [stm_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [7:0]                regRdata,
  input  wire logic                      highClockTick,
  input  wire logic                      timeBaseTick,
  input  wire logic                      externalClockPin,
  input  wire logic                      capturePin,
  output logic                           waveformOutputPin,
  output logic                           matchAIrq,
  output logic                           matchPIrq,
  output logic                           moduleActive
);
  // whole module state in one struct
  typedef struct packed {
    stm_pkg::stm_ctrl0_t ctrl0;       // timer_control_0
    stm_pkg::stm_ctrl1_t ctrl1;       // timer_control_1
    logic [CNT_W-1:0]    count;       // the counter
    logic [CNT_W-1:0]    compareA;    // compare_a_value
    logic [7:0]          lowBuffer;   // shared low-byte buffer
    logic                outLevel;    // raw output before polarity
    logic                pulseArmed;  // single pulse in progress
    logic                enablePrev;  // enable history for edge
    logic [7:0]          rdata;       // read data, one cycle later
    logic                irqA;        // one-cycle match A pulse
    logic                irqP;        // one-cycle match P pulse
  } stm_core_state_t;

  stm_pkg::stm_bus_req_t req;      // bundled register request
  stm_core_state_t       st;       // registered state
  stm_core_state_t       next_st;  // next value
  logic                  tick;     // one timer clock this cycle
  logic                  extRise;  // external clock rising edge
  logic                  extFall;  // external clock falling edge
  logic                  capRise;  // capture pin rising edge
  logic                  capFall;  // capture pin falling edge
  stm_pkg::stm_events_t  ev;       // comparator results

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // pins pass two flops before use
  stm_sync u_ext_sync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (externalClockPin),
    .level (),
    .rise  (extRise),
    .fall  (extFall)
  );

  stm_sync u_cap_sync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (capturePin),
    .level (),
    .rise  (capRise),
    .fall  (capFall)
  );

  // timer clock source selection
  stm_tick_gen u_tick (
    .clk              (clk),
    .rst              (rst),
    .clockSelectField (st.ctrl0.clockSelectField),
    .highClockTick    (highClockTick),
    .timeBaseTick     (timeBaseTick),
    .extRise          (extRise),
    .extFall          (extFall),
    .tick             (tick)
  );

  // period compare: top three bits equal value; zero means full-scale overflow
  function automatic logic period_hit(input logic [CNT_W-1:0] cnt, input logic [stm_pkg::PER_W-1:0] per);
    period_hit = (per != '0) && (cnt[CNT_W-1 -: stm_pkg::PER_W] == per);
  endfunction

  // apply a compare-mode action to the current level
  function automatic logic compare_action(input logic [1:0] fn, input logic cur);
    unique case (fn)
      2'h0:    compare_action = cur;    // no change
      2'h1:    compare_action = 1'b0;   // drive low
      2'h2:    compare_action = 1'b1;   // drive high
      default: compare_action = ~cur;   // toggle
    endcase
  endfunction

  // comparator evaluation on the value the counter is about to reach; overflow on the current value
  always_comb begin
    ev          = '0;
    ev.matchA   = (st.count + CNT_W'(1)) == st.compareA && st.compareA != '0;
    ev.matchP   = period_hit(st.count + CNT_W'(1), st.ctrl0.periodValueField);
    ev.overflow = st.count == {CNT_W{1'b1}};
  end

  // main next-state logic
  always_comb begin
    logic run;
    logic enRise;
    logic clearHit;
    logic isSwap;
    logic [CNT_W-1:0] periodEdge;
    run        = 1'b0;
    enRise     = 1'b0;
    clearHit   = 1'b0;
    isSwap     = 1'b0;
    periodEdge = '0;
    next_st    = st;
    next_st.irqA       = 1'b0;
    next_st.irqP       = 1'b0;
    next_st.enablePrev = st.ctrl0.moduleEnableBit;
    enRise = st.ctrl0.moduleEnableBit & ~st.enablePrev;
    // enable high, not paused, timer clock present
    run = st.ctrl0.moduleEnableBit && !st.ctrl0.pauseBit && tick;
    isSwap = st.ctrl1.dutyPeriodSwapBit;
    periodEdge = {st.ctrl0.periodValueField, {(CNT_W-stm_pkg::PER_W){1'b0}}};

    if (enRise) begin
      next_st.count = '0;
      next_st.pulseArmed = st.ctrl1.outputFunctionField == 2'h3;
      // restore initial level in output modes
      if (st.ctrl1.modeField != stm_pkg::MODE_TIMER &&
          st.ctrl1.modeField != stm_pkg::MODE_CAPTURE) begin
        next_st.outLevel = (st.ctrl1.modeField == stm_pkg::MODE_COMPARE)
                           ? st.ctrl1.outputControlBit : 1'b0;
      end
    end else if (run) begin
      // clear source decides which match wraps the counter; PWM mode always wraps on period
      if (st.ctrl1.clearSourceBit && st.ctrl1.modeField != stm_pkg::MODE_PWM) begin
        clearHit = ev.matchA;
      end else begin
        clearHit = ev.matchP;
      end
      if (clearHit || ev.overflow) begin
        next_st.count = '0;
      end else begin
        next_st.count = st.count + CNT_W'(1);
      end
      next_st.irqA = ev.matchA;
      next_st.irqP = (ev.matchP || (ev.overflow && st.ctrl0.periodValueField == '0)) &&
                     !(st.ctrl1.clearSourceBit && st.ctrl1.modeField != stm_pkg::MODE_PWM);
      // output behaviour by mode
      unique case (st.ctrl1.modeField)
        stm_pkg::MODE_COMPARE: begin
          if (ev.matchA) begin
            // equal-to-initial request leaves pin unchanged
            next_st.outLevel = compare_action(st.ctrl1.outputFunctionField, st.outLevel);
          end
        end
        stm_pkg::MODE_PWM: begin
          unique case (st.ctrl1.outputFunctionField)
            2'h0: next_st.outLevel = 1'b0;                         // inactive
            2'h1: next_st.outLevel = 1'b1;                         // active
            2'h2: begin
              // active until duty match, inactive to period end
              if (next_st.count == '0) begin
                next_st.outLevel = 1'b1;
              end else if (isSwap ? (next_st.count == periodEdge) : ev.matchA) begin
                next_st.outLevel = 1'b0;
              end
            end
            default: begin
              // one active pulse from enable until compare A
              next_st.outLevel = st.pulseArmed && !ev.matchA;
              if (ev.matchA) begin
                next_st.pulseArmed = 1'b0;
              end
            end
          endcase
        end
        default: begin
          // timer mode: pin is don't-care, capture handled below
          next_st.outLevel = st.outLevel;
        end
      endcase
    end

    // capture copies count into compare A on the chosen edge
    if (st.ctrl1.modeField == stm_pkg::MODE_CAPTURE && st.ctrl0.moduleEnableBit) begin
      unique case (st.ctrl1.outputFunctionField)
        2'h0:    if (capRise) next_st.compareA = st.count;
        2'h1:    if (capFall) next_st.compareA = st.count;
        2'h2:    if (capRise || capFall) next_st.compareA = st.count;
        default: next_st.compareA = st.compareA;                   // disabled
      endcase
      if ((capRise && st.ctrl1.outputFunctionField == 2'h0) ||
          (capFall && st.ctrl1.outputFunctionField == 2'h1) ||
          ((capRise || capFall) && st.ctrl1.outputFunctionField == 2'h2)) begin
        next_st.irqA = 1'b1;
      end
    end

    // register writes; mode changes while on are the user's problem
    if (req.wr) begin
      unique case (req.addr)
        stm_pkg::ADDR_CTRL0:   next_st.ctrl0 = stm_pkg::stm_ctrl0_t'(req.wdata);
        stm_pkg::ADDR_CTRL1:   next_st.ctrl1 = stm_pkg::stm_ctrl1_t'(req.wdata);
        stm_pkg::ADDR_CMPA_LO: next_st.lowBuffer = req.wdata;
        stm_pkg::ADDR_CMPA_HI: next_st.compareA = {req.wdata[CNT_W-9:0], st.lowBuffer};
        default: next_st.lowBuffer = st.lowBuffer;                  // counter is read-only
      endcase
    end

    // register reads answered the following cycle
    next_st.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        stm_pkg::ADDR_CTRL0:   next_st.rdata = st.ctrl0;
        stm_pkg::ADDR_CTRL1:   next_st.rdata = st.ctrl1;
        stm_pkg::ADDR_CNT_LO,
        stm_pkg::ADDR_CMPA_LO: next_st.rdata = st.lowBuffer;
        stm_pkg::ADDR_CNT_HI: begin
          next_st.rdata     = {6'h00, st.count[CNT_W-1:8]};
          next_st.lowBuffer = st.count[7:0];
        end
        stm_pkg::ADDR_CMPA_HI: begin
          next_st.rdata     = {6'h00, st.compareA[CNT_W-1:8]};
          next_st.lowBuffer = st.compareA[7:0];
        end
        default: next_st.rdata = '0;                                // unmapped reads zero
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs; polarity skipped in timer mode
  assign regRdata          = st.rdata;
  assign waveformOutputPin = (st.ctrl1.modeField == stm_pkg::MODE_TIMER) ? st.outLevel
                             : st.outLevel ^ st.ctrl1.polarityBit;
  assign matchAIrq         = st.irqA;
  assign matchPIrq         = st.irqP;
  assign moduleActive      = st.ctrl0.moduleEnableBit;              // low means reduced power
endmodule

// [shared/stm_pkg.sv]
// package for the standard timer core: register map, field layout, encodings
// assumes a plain strobe register port and a single 200 MHz clock
package stm_pkg;
  // register indices on the plain port
  localparam logic [2:0] ADDR_CTRL0   = 3'h0; // timer_control_0
  localparam logic [2:0] ADDR_CTRL1   = 3'h1; // timer_control_1
  localparam logic [2:0] ADDR_CNT_LO  = 3'h2; // count_low_byte
  localparam logic [2:0] ADDR_CNT_HI  = 3'h3; // count_high_bits
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4; // compare_a_low_byte
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5; // compare_a_high_bits
  localparam int         ADDR_W       = 3;
  localparam int         CNT_W        = 10;   // counter width
  localparam int         PER_W        = 3;    // period compare width
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] HI_PAD       = 2'h0;

  // clock select encodings
  localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CK_SYS       = 3'h1;
  localparam logic [2:0] CK_HI_DIV16  = 3'h2;
  localparam logic [2:0] CK_HI_DIV64  = 3'h3;
  localparam logic [2:0] CK_TB_A      = 3'h4;
  localparam logic [2:0] CK_TB_B      = 3'h5;
  localparam logic [2:0] CK_EXT_RISE  = 3'h6;
  localparam logic [2:0] CK_EXT_FALL  = 3'h7;
  localparam logic [5:0] DIV4_MASK    = 6'h03;
  localparam logic [5:0] DIV16_MASK   = 6'h0f;
  localparam logic [5:0] DIV64_MASK   = 6'h3f;

  // operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } stm_mode_t;

  // control register 0 layout
  typedef struct packed {
    logic             pauseBit;
    logic [2:0]       clockSelectField;
    logic             moduleEnableBit;
    logic [PER_W-1:0] periodValueField;
  } stm_ctrl0_t;

  // control register 1 layout
  typedef struct packed {
    stm_mode_t  modeField;
    logic [1:0] outputFunctionField;
    logic       outputControlBit;
    logic       polarityBit;
    logic       dutyPeriodSwapBit;
    logic       clearSourceBit;
  } stm_ctrl1_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } stm_bus_req_t;

  // compare events of one counter step
  typedef struct packed {
    logic matchA;
    logic matchP;
    logic overflow;
  } stm_events_t;
endpackage

// [src/stm_sync.sv]
// two-stage synchroniser with edge detection on the second stage output
// assumes pin input is asynchronous to clk
`timescale 1ns/1ps
module stm_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  // state: two sync stages plus history for edges
  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } stm_sync_state_t;

  stm_sync_state_t st;      // registered state
  stm_sync_state_t next_st; // next value

  // shift chain; only stage two feeds the edge logic
  always_comb begin
    next_st        = st;
    next_st.meta   = pinIn;
    next_st.stable = st.meta;
    next_st.prev   = st.stable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.stable;
  assign rise  = st.stable & ~st.prev;
  assign fall  = ~st.stable & st.prev;
endmodule

// [src/stm_tick_gen.sv]
// timer clock tick generator: one-cycle enable per selected timer clock edge
// assumes time-base and high-clock ticks arrive as clk-synchronous pulses
`timescale 1ns/1ps
module stm_tick_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] clockSelectField,
  input  wire logic       highClockTick,
  input  wire logic       timeBaseTick,
  input  wire logic       extRise,
  input  wire logic       extFall,
  output logic            tick
);
  // state: free prescalers for system and high clock
  typedef struct packed {
    logic [5:0] sysDiv;
    logic [5:0] hiDiv;
  } stm_tick_state_t;

  stm_tick_state_t st;      // registered state
  stm_tick_state_t next_st; // next value

  // prescalers advance regardless of selection, like free dividers
  always_comb begin
    next_st        = st;
    next_st.sysDiv = st.sysDiv + 6'h01;
    if (highClockTick) begin
      next_st.hiDiv = st.hiDiv + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // source select decode
  always_comb begin
    unique case (clockSelectField)
      stm_pkg::CK_SYS_DIV4: tick = (st.sysDiv & stm_pkg::DIV4_MASK) == stm_pkg::DIV4_MASK;
      stm_pkg::CK_SYS:      tick = 1'b1;
      stm_pkg::CK_HI_DIV16: tick = highClockTick && ((st.hiDiv & stm_pkg::DIV16_MASK) == stm_pkg::DIV16_MASK);
      stm_pkg::CK_HI_DIV64: tick = highClockTick && ((st.hiDiv & stm_pkg::DIV64_MASK) == stm_pkg::DIV64_MASK);
      stm_pkg::CK_TB_A,
      stm_pkg::CK_TB_B:     tick = timeBaseTick;
      stm_pkg::CK_EXT_RISE: tick = extRise;
      stm_pkg::CK_EXT_FALL: tick = extFall;
      default:              tick = 1'b0;
    endcase
  end
endmodule

// [bench/stm_pin_model.sv]
// far-side pin model: external clock source and capture source
// assumes the bench calls pulses() from its main sequence; pins idle low
`timescale 1ns/1ps
module stm_pin_model (
  input  wire logic clk,
  input  wire logic waveIn,
  output logic      extPin,
  output logic      capPin
);
  // both sources rest low between bursts
  initial begin
    extPin = 1'b0;
    capPin = 1'b0;
  end

  // n full pulses, w cycles high and w low; small w is a fast source
  task automatic pulses(input bit onCap, input int n, input int w);
    repeat (n) begin
      repeat (w) @(posedge clk);
      if (onCap) capPin <= 1'b1;
      else extPin <= 1'b1;
      repeat (w) @(posedge clk);
      if (onCap) capPin <= 1'b0;
      else extPin <= 1'b0;
    end
  endtask
endmodule

// [bench/stm_core_monitor.sv]
// port checker for the timer core, bound into every core instance
// assumes single clock, synchronous active-high reset
`timescale 1ns/1ps
module stm_core_monitor #(
  parameter int CNT_W = 10 // counter width
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [stm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0]                 regWdata,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [7:0]                 regRdata,
  input wire logic                       highClockTick,
  input wire logic                       timeBaseTick,
  input wire logic                       externalClockPin,
  input wire logic                       capturePin,
  input wire logic                       waveformOutputPin,
  input wire logic                       matchAIrq,
  input wire logic                       matchPIrq,
  input wire logic                       moduleActive
);
  logic [7:0] ctrl0Sh; // shadow of control 0
  logic [7:0] ctrl1Sh; // shadow of control 1
  logic [2:0] wrAge;   // recent writes, settings may still be landing
  logic       cmpMode; // compare output mode selected

  assign cmpMode = ctrl1Sh[7:6] == 2'h0;

  // shadows follow the software view of the control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0Sh <= 8'h00;
      ctrl1Sh <= 8'h00;
      wrAge   <= 3'h0;
    end else begin
      if (regWr && regAddr == stm_pkg::ADDR_CTRL0) ctrl0Sh <= regWdata;
      if (regWr && regAddr == stm_pkg::ADDR_CTRL1) ctrl1Sh <= regWdata;
      wrAge <= {wrAge[1:0], regWr};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside read slot");
  ctrl_back_a: assert property (regRd && regAddr == stm_pkg::ADDR_CTRL0 |=> regRdata == $past(ctrl0Sh))
    else $error("control 0 read back differs");
  hi_pad_a: assert property (regRd && regAddr inside {3'h3, 3'h5} |=> regRdata[7:2] == 6'h00)
    else $error("high bits register upper bits not zero");
  a_pulse_a: assert property (matchAIrq |=> !matchAIrq)
    else $error("compare A request longer than one cycle");
  p_pulse_a: assert property (matchPIrq |=> !matchPIrq)
    else $error("period request longer than one cycle");
  act_on_a: assert property (regWr && regAddr == stm_pkg::ADDR_CTRL0 && regWdata[3] |-> ##[1:2] moduleActive)
    else $error("module did not switch on");
  act_off_a: assert property (regWr && regAddr == stm_pkg::ADDR_CTRL0 && !regWdata[3] |-> ##[1:2] !moduleActive)
    else $error("module did not switch off");
  no_pirq_a: assert property (ctrl1Sh[0] && ctrl1Sh[7:6] != 2'h2 && wrAge == 3'h0 && !regWr |-> !matchPIrq)
    else $error("period request while compare A clears");
  init_lvl_a: assert property ($rose(moduleActive) && cmpMode |-> ##[0:1] waveformOutputPin == (ctrl1Sh[3] ^ ctrl1Sh[2]))
    else $error("output not at initial level after switch on");
  out_hold_a: assert property (cmpMode && moduleActive && $past(moduleActive) && wrAge == 3'h0 && !matchAIrq
                               && !$past(matchAIrq) |-> $stable(waveformOutputPin))
    else $error("output moved without compare A match");

  // main scenarios reached
  cov_a: cover property (matchAIrq);
  cov_p: cover property (matchPIrq);
  cov_on: cover property ($rose(moduleActive));
endmodule

bind stm_core stm_core_monitor #(.CNT_W(CNT_W)) u_mon (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .highClockTick(highClockTick),
  .timeBaseTick(timeBaseTick), .externalClockPin(externalClockPin), .capturePin(capturePin),
  .waveformOutputPin(waveformOutputPin), .matchAIrq(matchAIrq), .matchPIrq(matchPIrq),
  .moduleActive(moduleActive));

// [bench/stm_core_tb.sv]
// self-checking bench for the timer core, one task per scenario
// assumes the pin model owns the external clock and capture pins
`timescale 1ns/1ps
module stm_core_tb;
  logic       clk;      // 200 MHz
  logic       rst;      // sync, active high
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       hiTick;   // high clock: a tick every cycle
  logic       tbTick;   // time base: a tick every other cycle
  logic       extPin;
  logic       capPin;
  logic       wave;
  logic       matchAIrq;
  logic       matchPIrq;
  logic       moduleActive;
  int         failures;
  int         nTests;

  stm_core #(.CNT_W(10)) u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .highClockTick(hiTick), .timeBaseTick(tbTick),
    .externalClockPin(extPin), .capturePin(capPin), .waveformOutputPin(wave), .matchAIrq(matchAIrq),
    .matchPIrq(matchPIrq), .moduleActive(moduleActive));
  stm_pin_model u_pins (.clk(clk), .waveIn(wave), .extPin(extPin), .capPin(capPin));

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // time base ticks, one every second cycle
  always @(posedge clk) tbTick <= rst ? 1'b0 : ~tbTick;

  // step past an edge so registered outputs have settled
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  // high first, so the low byte is latched with it
  task automatic rdCnt(output logic [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(stm_pkg::ADDR_CNT_HI, h);
    rd(stm_pkg::ADDR_CNT_LO, l);
    v = {h[1:0], l};
  endtask

  function automatic bit irqSeen(input bit useA);
    return useA ? (matchAIrq === 1'b1) : (matchPIrq === 1'b1);
  endfunction

  // cycles between two consecutive requests, bounded
  task automatic gap(input bit useA, output int n);
    for (int k = 0; k < 2100 && !irqSeen(useA); k++) tick();
    n = 0;
    do begin
      tick();
      n++;
    end while (n < 2100 && !irqSeen(useA));
  endtask

  task automatic waitA(output bit got);
    got = 1'b0;
    for (int k = 0; k < 1100 && !got; k++) begin
      tick();
      got = irqSeen(1'b1);
    end
  endtask

  // reset values, unmapped place, buffered compare A access
  task automatic regTest();
    logic [7:0] v;
    rd(3'h0, v);
    check("ctrl0", v, 8'h00);
    rd(3'h1, v);
    check("ctrl1", v, 8'h00);
    rd(3'h6, v);
    check("unmapped", v, 8'h00);
    wr(3'h4, 8'h05);
    wr(3'h5, 8'h01);
    wr(3'h4, 8'h77); // buffered only, never committed
    rd(3'h5, v);
    check("cmpA hi", v, 8'h01);
    rd(3'h4, v);
    check("cmpA lo", v, 8'h05);
  endtask

  // period compare lengths, clear source zero; compare A clear length
  task automatic periodTest();
    int n;
    int p;
    for (int i = 0; i < 3; i++) begin
      p = (i == 2) ? 7 : i;
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h18 | p[7:0]);
      gap(1'b0, n);
      check("period gap", n[15:0], (p == 0) ? 16'd1024 : p[15:0] * 16'd128);
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h18);
    gap(1'b1, n);
    check("cmpA gap", n[15:0], 16'd261);
  endtask

  // every function, initial level and polarity in compare output mode
  task automatic outTest();
    logic lvl;
    bit   got;
    for (int c = 0; c < 16; c++) begin
      wr(3'h0, 8'h00); // off before mode change
      wr(3'h1, {2'b00, c[3:2], c[1], c[0], 2'b01});
      wr(3'h0, 8'h18);
      repeat (3) tick();
      check("init level", wave, c[1] ^ c[0]);
      waitA(got);
      repeat (2) tick();
      check("match seen", got, 1'b1);
      case (c[3:2])
        2'h0: lvl = c[1];
        2'h1: lvl = 1'b0;
        2'h2: lvl = 1'b1;
        default: lvl = ~c[1];
      endcase
      check("match level", wave, lvl ^ c[0]);
    end
  endtask

  // PWM duty: high from wrap until compare A
  task automatic pwmTest();
    int n;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'ha0);
    wr(3'h0, 8'h1f);
    for (int k = 0; k < 1000 && wave !== 1'b1; k++) tick();
    for (n = 0; n < 1000 && wave === 1'b1; n++) tick();
    check("pwm duty", n[15:0], 16'd261);
  endtask

  // pause, switch off, switch on in compare mode
  task automatic holdTest();
    logic [9:0] v1;
    logic [9:0] v2;
    logic [9:0] v3;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h18);
    repeat (50) tick();
    wr(3'h0, 8'h98);
    rdCnt(v1);
    repeat (20) tick();
    rdCnt(v2);
    check("paused", v2, v1);
    wr(3'h2, 8'h55); // count is read only
    rdCnt(v2);
    check("no load", v2, v1);
    wr(3'h0, 8'h18);
    repeat (10) tick();
    wr(3'h0, 8'h10);
    rdCnt(v3);
    repeat (10) tick();
    rdCnt(v2);
    check("off holds", v2, v3);
    check("resumed", (v3 - v1) inside {[10'd10 : 10'd15]}, 1'b1);
    wr(3'h0, 8'h98);
    rdCnt(v2);
    check("on clears", v2, 10'h000);
  endtask

  // every clock source; span from switch on to pause is about 130 cycles
  task automatic clockTest();
    logic [9:0] v;
    int         e[6] = '{32, 130, 8, 2, 65, 65};
    for (int s = 0; s < 6; s++) begin
      wr(3'h0, 8'h00);
      wr(3'h0, {1'b0, s[2:0], 4'h8});
      repeat (128) tick();
      wr(3'h0, {1'b1, s[2:0], 4'h8});
      rdCnt(v);
      check("clock sel", (int'(v) >= e[s] - 2 && int'(v) <= e[s] + 2), 1'b1);
    end
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h68);
    u_pins.pulses(1'b0, 5, 2);
    repeat (8) tick();
    rdCnt(v);
    check("ext rise", v, 10'd5);
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h78);
    u_pins.pulses(1'b0, 3, 6);
    repeat (8) tick();
    rdCnt(v);
    check("ext fall", v, 10'd3);
  endtask

  // capture edge choices, counter paused so no compare match interferes
  task automatic captureTest();
    int nA;
    int e[4] = '{1, 1, 2, 0};
    for (int f = 0; f < 4; f++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, {2'b01, f[1:0], 4'h0});
      wr(3'h0, 8'h98);
      nA = 0;
      fork
        u_pins.pulses(1'b1, 1, 4);
        repeat (16) begin
          tick();
          nA += irqSeen(1'b1);
        end
      join
      check("captures", nA[15:0], e[f][15:0]);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog, about four times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst      = 1'b1;
    regAddr  = 3'h0;
    regWdata = 8'h00;
    regWr    = 1'b0;
    regRd    = 1'b0;
    hiTick   = 1'b1;
    failures = 0;
    nTests   = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    regTest();
    periodTest();
    outTest();
    pwmTest();
    holdTest();
    clockTest();
    captureTest();
    end_of_test();
  end
endmodule
